/* File: rtl/frame_reader_pkg.sv */
// Purpose: shared constants for the frame reader and its stream sink
// Assumes: 32-bit apb data, byte addresses on paddr
// Notes: offsets are byte addresses of aligned words
package frame_reader_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_SELECT = 8'h10;
  localparam logic [7:0] OFS_ADDR0 = 8'h14;
  localparam logic [7:0] OFS_WORDS0 = 8'h18;
  localparam logic [7:0] OFS_PATS0 = 8'h1c;
  localparam logic [7:0] OFS_ADDR1 = 8'h20;
  localparam logic [7:0] OFS_WORDS1 = 8'h24;
  localparam logic [7:0] OFS_PATS1 = 8'h28;
  localparam logic [7:0] OFS_WIDTH = 8'h2c;
  localparam logic [7:0] OFS_HEIGHT = 8'h30;
  localparam logic [7:0] OFS_ILACE = 8'h34;
  // ----------------------------------------------------------------
  // stream packet layout
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int DIM_W = 16;
  localparam logic [3:0] PKT_CTRL = 4'hf;
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] CTL_LAST = 4'h9;
  localparam int MAX_PLANES_PAR = 4;
  localparam int MAX_PLANES_SEQ = 3;
endpackage

/* File: rtl/vid_stream_if.sv */
// Purpose: pixel stream between frame reader and downstream logic
// Assumes: one clock shared by both ends
// Notes: a beat moves on a rising edge with vld and rdy both high
`timescale 1ns/10ps
`default_nettype none
interface vid_stream_if #(parameter int DW = 24);
  logic vld;
  logic rdy;
  logic [DW-1:0] data;
  logic sop;
  logic eop;
  modport src (output vld, output data, output sop, output eop, input rdy);
  modport snk (input vld, input data, input sop, input eop, output rdy);
endinterface
`default_nettype wire

/* File: rtl/word_unpacker.sv */
// Purpose: splits one memory word into whole colour patterns
// Assumes: a load may come while patterns remain; it replaces them
// Notes: spare high bits of the word are never shifted out
`timescale 1ns/10ps
`default_nettype none
module word_unpacker #(
  parameter int MEM_W = 64,
  parameter int PAT_W = 24
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // word side
  input wire logic load_i,
  input wire logic [MEM_W-1:0] word_i,
  // pattern side
  input wire logic take_i,
  output logic [PAT_W-1:0] pat_o,
  output logic have_o
);
  localparam int PPW = MEM_W / PAT_W;
  localparam int LW = $clog2(PPW + 1);
  typedef struct packed {
    logic [MEM_W-1:0] word;
    logic [LW-1:0] left;
  } q_s;
  q_s q_r;
  q_s q_nxt;

  // lowest pattern leaves first, then shift toward it
  always_comb
  begin
    q_nxt = q_r;
    if (load_i)
    begin
      q_nxt.word = word_i;
      q_nxt.left = LW'(PPW);
    end
    else if (take_i && q_r.left != '0)
    begin
      q_nxt.word = q_r.word >> PAT_W;
      q_nxt.left = q_r.left - LW'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign pat_o = q_r.word[PAT_W-1:0];
  assign have_o = (q_r.left != '0);
endmodule
`default_nettype wire

/* File: rtl/frame_reader.sv */
// Purpose: reads raw frames from memory and streams control + video packets
// Assumes: single clock; memory read master holds read until wait is low
// Notes: apb slave answers in two access cycles; one read outstanding
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - control packet and video header precede fetches
// - fetched patterns form payload, repeated per frame
// - programmed width, height, interlace fill control packet
// - planes times bits fixes pattern width
// - sequence count leaves pattern width unchanged
// - software gives pattern count per frame
// - software gives word count, master width
// - only whole patterns per word, spare top
// - lowest-bit pattern of word goes first
// - fetch from start address upward
// - software sets start address before reading
// - two locations, one selector picks
// - one frame-done interrupt per video packet
// - at most four parallel, three sequential
// - width, height bounded; any interlace value
module frame_reader #(
  parameter int BITS = 8,
  parameter int PLANES = 3,
  parameter int SEQ = 3,
  parameter int MEM_W = 64,
  parameter int CNT_W = 24,
  parameter logic [15:0] MAX_WIDTH = 16'h0780,
  parameter logic [15:0] MAX_HEIGHT = 16'h0438
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // apb register port
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [frame_reader_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  // memory read master
  output logic MEM_RD_O,
  output logic [31:0] MEM_ADDR_O,
  input wire logic MEM_WAIT_I,
  input wire logic [MEM_W-1:0] MEM_RDATA_I,
  input wire logic MEM_RVALID_I,
  // pixel stream out
  vid_stream_if.src VID_SRC
);
  // ----------------------------------------------------------------
  // build-time shape
  // ----------------------------------------------------------------
  localparam int PL = (PLANES > frame_reader_pkg::MAX_PLANES_PAR) ?
    frame_reader_pkg::MAX_PLANES_PAR : PLANES;
  localparam int SQ = (SEQ > frame_reader_pkg::MAX_PLANES_SEQ) ?
    frame_reader_pkg::MAX_PLANES_SEQ : SEQ;
  localparam int PAT_W = PL * BITS;
  localparam logic [31:0] WORD_BYTES = 32'(MEM_W / 8);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CTL = 6'h02,
    S_VHDR = 6'h04,
    S_READ = 6'h08,
    S_RWAIT = 6'h10,
    S_SEND = 6'h20
  } st_e;

  typedef struct packed {
    st_e state;
    logic [3:0] beat;
    logic sv;
    logic [PAT_W-1:0] sd;
    logic ssop;
    logic seop;
    logic svid;
    logic mrd;
    logic [31:0] maddr;
    logic [CNT_W-1:0] words;
    logic [CNT_W-1:0] pats;
    logic go;
    logic sel;
    logic [31:0] addr0;
    logic [31:0] addr1;
    logic [CNT_W-1:0] wc0;
    logic [CNT_W-1:0] wc1;
    logic [CNT_W-1:0] pc0;
    logic [CNT_W-1:0] pc1;
    logic [15:0] width;
    logic [15:0] height;
    logic [3:0] ilace;
    logic [15:0] fw;
    logic [15:0] fh;
    logic [3:0] fi;
    logic irq_st;
    logic irq_mk;
    logic irq;
    logic rdy;
    logic [31:0] rdata;
    logic err;
  } q_s;

  q_s q_r;
  q_s q_nxt;
  logic ld;
  logic take;
  logic [MEM_W-1:0] ld_word;
  logic [PAT_W-1:0] pat;
  logic have;
  logic acc;
  logic free;
  logic wr;

  // saturate a dimension at its build-time ceiling
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction

  // control payload nibbles: width, height msb first, then interlace
  function automatic logic [3:0] ctl_nib(input logic [3:0] b, input logic [15:0] w,
                                         input logic [15:0] h, input logic [3:0] il);
    logic [35:0] all;
    all = {w, h, il};
    ctl_nib = all[35 - 4 * (32'(b) - 1) -: 4];
  endfunction

  word_unpacker #(.MEM_W(MEM_W), .PAT_W(PAT_W)) u_unpack (
    .CLK_SYS_I(CLK_SYS_I),
    .ARST_N_I(ARST_N_I),
    .load_i(ld),
    .word_i(ld_word),
    .take_i(take),
    .pat_o(pat),
    .have_o(have)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    ld = 1'b0;
    take = 1'b0;
    ld_word = '0;
    acc = q_r.sv & VID_SRC.rdy;
    free = !q_r.sv | VID_SRC.rdy; // a beat may be replaced as it leaves
    if (acc)
      q_nxt.sv = 1'b0;
    // apb: answer one cycle into access so read data comes from a flop
    q_nxt.rdy = PSEL_I & PENABLE_I & !q_r.rdy;
    q_nxt.err = 1'b0;
    q_nxt.rdata = '0;
    wr = PSEL_I & PENABLE_I & q_r.rdy & PWRITE_I;
    if (q_nxt.rdy)
    begin
      case (PADDR_I)
        frame_reader_pkg::OFS_CTRL: q_nxt.rdata[0] = q_r.go;
        frame_reader_pkg::OFS_STATUS: q_nxt.rdata[0] = (q_r.state != S_IDLE);
        frame_reader_pkg::OFS_IRQ_STAT: q_nxt.rdata[0] = q_r.irq_st;
        frame_reader_pkg::OFS_IRQ_MASK: q_nxt.rdata[0] = q_r.irq_mk;
        frame_reader_pkg::OFS_SELECT: q_nxt.rdata[0] = q_r.sel;
        frame_reader_pkg::OFS_ADDR0: q_nxt.rdata = q_r.addr0;
        frame_reader_pkg::OFS_WORDS0: q_nxt.rdata[CNT_W-1:0] = q_r.wc0;
        frame_reader_pkg::OFS_PATS0: q_nxt.rdata[CNT_W-1:0] = q_r.pc0;
        frame_reader_pkg::OFS_ADDR1: q_nxt.rdata = q_r.addr1;
        frame_reader_pkg::OFS_WORDS1: q_nxt.rdata[CNT_W-1:0] = q_r.wc1;
        frame_reader_pkg::OFS_PATS1: q_nxt.rdata[CNT_W-1:0] = q_r.pc1;
        frame_reader_pkg::OFS_WIDTH: q_nxt.rdata[15:0] = q_r.width;
        frame_reader_pkg::OFS_HEIGHT: q_nxt.rdata[15:0] = q_r.height;
        frame_reader_pkg::OFS_ILACE: q_nxt.rdata[3:0] = q_r.ilace;
        default: q_nxt.err = 1'b1;
      endcase
    end
    // register writes take effect on the completing edge only
    if (wr)
    begin
      case (PADDR_I)
        frame_reader_pkg::OFS_CTRL: q_nxt.go = PWDATA_I[0];
        frame_reader_pkg::OFS_IRQ_STAT: q_nxt.irq_st = q_r.irq_st & !PWDATA_I[0];
        frame_reader_pkg::OFS_IRQ_MASK: q_nxt.irq_mk = PWDATA_I[0];
        frame_reader_pkg::OFS_SELECT: q_nxt.sel = PWDATA_I[0];
        frame_reader_pkg::OFS_ADDR0: q_nxt.addr0 = PWDATA_I;
        frame_reader_pkg::OFS_WORDS0: q_nxt.wc0 = PWDATA_I[CNT_W-1:0];
        frame_reader_pkg::OFS_PATS0: q_nxt.pc0 = PWDATA_I[CNT_W-1:0];
        frame_reader_pkg::OFS_ADDR1: q_nxt.addr1 = PWDATA_I;
        frame_reader_pkg::OFS_WORDS1: q_nxt.wc1 = PWDATA_I[CNT_W-1:0];
        frame_reader_pkg::OFS_PATS1: q_nxt.pc1 = PWDATA_I[CNT_W-1:0];
        frame_reader_pkg::OFS_WIDTH: q_nxt.width = clamp(PWDATA_I[15:0], MAX_WIDTH);
        frame_reader_pkg::OFS_HEIGHT: q_nxt.height = clamp(PWDATA_I[15:0], MAX_HEIGHT);
        frame_reader_pkg::OFS_ILACE: q_nxt.ilace = PWDATA_I[3:0];
        default: ;
      endcase
    end

    // frame sequencer
    unique case (q_r.state)
      S_IDLE:
      begin
        // snapshot so a mid-frame register write cannot tear a frame
        if (q_r.go)
        begin
          q_nxt.state = S_CTL;
          q_nxt.beat = '0;
          q_nxt.maddr = q_r.sel ? q_r.addr1 : q_r.addr0;
          q_nxt.words = q_r.sel ? q_r.wc1 : q_r.wc0;
          q_nxt.pats = q_r.sel ? q_r.pc1 : q_r.pc0;
          q_nxt.fw = q_r.width;
          q_nxt.fh = q_r.height;
          q_nxt.fi = q_r.ilace;
        end
      end
      S_CTL:
      begin
        if (free)
        begin
          q_nxt.sv = 1'b1;
          q_nxt.svid = 1'b0;
          q_nxt.ssop = (q_r.beat == '0);
          q_nxt.seop = (q_r.beat == frame_reader_pkg::CTL_LAST);
          q_nxt.sd = '0;
          q_nxt.sd[3:0] = (q_r.beat == '0) ? frame_reader_pkg::PKT_CTRL :
            ctl_nib(q_r.beat, q_r.fw, q_r.fh, q_r.fi);
          q_nxt.beat = q_r.beat + 4'h1;
          if (q_r.beat == frame_reader_pkg::CTL_LAST)
            q_nxt.state = S_VHDR;
        end
      end
      S_VHDR:
      begin
        // an empty frame is a header that is also its own last beat
        if (free)
        begin
          q_nxt.sv = 1'b1;
          q_nxt.sd = '0;
          q_nxt.sd[3:0] = frame_reader_pkg::PKT_VIDEO;
          q_nxt.ssop = 1'b1;
          q_nxt.seop = (q_r.pats == '0);
          q_nxt.svid = 1'b1;
          q_nxt.state = (q_r.pats == '0) ? S_IDLE : S_READ;
        end
      end
      S_READ:
      begin
        // word budget spent: feed zero patterns until the count is met
        if (q_r.words == '0)
        begin
          ld = 1'b1;
          q_nxt.state = S_SEND;
        end
        else if (!q_r.mrd)
          q_nxt.mrd = 1'b1;
        else if (!MEM_WAIT_I)
        begin
          q_nxt.mrd = 1'b0;
          q_nxt.maddr = q_r.maddr + WORD_BYTES;
          q_nxt.words = q_r.words - CNT_W'(1);
          q_nxt.state = S_RWAIT;
        end
      end
      S_RWAIT:
      begin
        if (MEM_RVALID_I)
        begin
          ld = 1'b1;
          ld_word = MEM_RDATA_I;
          q_nxt.state = S_SEND;
        end
      end
      S_SEND:
      begin
        if (!have)
          q_nxt.state = S_READ;
        else if (free)
        begin
          q_nxt.sv = 1'b1;
          q_nxt.sd = pat;
          q_nxt.ssop = 1'b0;
          q_nxt.seop = (q_r.pats == CNT_W'(1));
          q_nxt.svid = 1'b1;
          take = 1'b1;
          q_nxt.pats = q_r.pats - CNT_W'(1);
          if (q_r.pats == CNT_W'(1))
            q_nxt.state = S_IDLE;
        end
      end
      default: q_nxt.state = S_IDLE;
    endcase

    // frame done when the video packet's last beat is taken; set beats clear
    if (acc && q_r.seop && q_r.svid)
      q_nxt.irq_st = 1'b1;
    q_nxt.irq = q_nxt.irq_st & q_nxt.irq_mk;
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      q_r <= '0;
      q_r.state <= S_IDLE;
    end
    else
      q_r <= q_nxt;
  end

  // ----------------------------------------------------------------
  // outputs straight from state
  // ----------------------------------------------------------------
  assign PRDATA_O = q_r.rdata;
  assign PREADY_O = q_r.rdy;
  assign PSLVERR_O = q_r.err;
  assign IRQ_O = q_r.irq;
  assign MEM_RD_O = q_r.mrd;
  assign MEM_ADDR_O = q_r.maddr;
  assign VID_SRC.vld = q_r.sv;
  assign VID_SRC.data = q_r.sd;
  assign VID_SRC.sop = q_r.ssop;
  assign VID_SRC.eop = q_r.seop;
endmodule
`default_nettype wire

/* File: rtl/frame_sink.sv */
// Purpose: downstream end: decodes control packets, passes pixels out
// Assumes: first beat of each packet carries its type in bits 3:0
// Notes: stall input throttles the stream through a registered ready
`timescale 1ns/10ps
`default_nettype none
module frame_sink #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // user side
  input wire logic STALL_I,
  output logic [DW-1:0] PIX_O,
  output logic PIX_VLD_O,
  output logic PIX_EOP_O,
  output logic FRAME_DONE_O,
  output logic [15:0] WIDTH_O,
  output logic [15:0] HEIGHT_O,
  output logic [3:0] ILACE_O,
  // pixel stream in
  vid_stream_if.snk VID_SNK
);
  typedef struct packed {
    logic rdy;
    logic is_ctl;
    logic is_vid;
    logic [31:0] sr;
    logic [DW-1:0] pix;
    logic pv;
    logic pe;
    logic done;
    logic [15:0] w;
    logic [15:0] h;
    logic [3:0] il;
  } q_s;
  q_s q_r;
  q_s q_nxt;
  logic acc;

  // ready is one cycle behind stall, so a stall costs one more beat
  always_comb
  begin
    q_nxt = q_r;
    acc = VID_SNK.vld & q_r.rdy;
    q_nxt.rdy = !STALL_I;
    q_nxt.pv = 1'b0;
    q_nxt.pe = 1'b0;
    q_nxt.done = 1'b0;
    if (acc && VID_SNK.sop)
    begin
      q_nxt.is_ctl = (VID_SNK.data[3:0] == frame_reader_pkg::PKT_CTRL);
      q_nxt.is_vid = (VID_SNK.data[3:0] == frame_reader_pkg::PKT_VIDEO);
      q_nxt.done = VID_SNK.eop &&
        (VID_SNK.data[3:0] == frame_reader_pkg::PKT_VIDEO);
    end
    else if (acc && q_r.is_ctl)
    begin
      q_nxt.sr = {q_r.sr[27:0], VID_SNK.data[3:0]};
      if (VID_SNK.eop)
      begin
        q_nxt.w = q_r.sr[31:16];
        q_nxt.h = q_r.sr[15:0];
        q_nxt.il = VID_SNK.data[3:0];
      end
    end
    else if (acc && q_r.is_vid)
    begin
      q_nxt.pix = VID_SNK.data;
      q_nxt.pv = 1'b1;
      q_nxt.pe = VID_SNK.eop;
      q_nxt.done = VID_SNK.eop;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign VID_SNK.rdy = q_r.rdy;
  assign PIX_O = q_r.pix;
  assign PIX_VLD_O = q_r.pv;
  assign PIX_EOP_O = q_r.pe;
  assign FRAME_DONE_O = q_r.done;
  assign WIDTH_O = q_r.w;
  assign HEIGHT_O = q_r.h;
  assign ILACE_O = q_r.il;
endmodule
`default_nettype wire

/* File: tb/frame_stream_assertions.sv */
// Purpose: stream checks between frame reader and sink
// Assumes: one clock; patterns at least 4 bits wide
// Notes: beat index restarts after every end of packet
`timescale 1ns/10ps
`default_nettype none
module frame_stream_assertions #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // stream signals
  input wire logic vld,
  input wire logic rdy,
  input wire logic [DW-1:0] data,
  input wire logic sop,
  input wire logic eop
);
  // ----------------------------------------------------------------
  // packet tracking
  // ----------------------------------------------------------------
  logic [7:0] idx_r;
  logic ctl_r;
  wire logic take = vld && rdy;
  // ctl_r flips at every end of packet, so control and video alternate
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      idx_r <= 8'h00;
      ctl_r <= 1'b1;
    end
    else if (take)
    begin
      idx_r <= eop ? 8'h00 : idx_r + 8'h01;
      ctl_r <= eop ? !ctl_r : ctl_r;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_hold_valid: assert property (vld && !rdy |=> vld)
    else $error("valid dropped before acceptance");
  a_hold_beat: assert property (vld && !rdy |=> $stable(data) && $stable(sop) && $stable(eop))
    else $error("beat changed while stalled");
  a_pkt_type: assert property (vld && sop |-> data[3:0] == (ctl_r ? 4'hf : 4'h0))
    else $error("wrong packet type order");
  a_sop_first: assert property (vld |-> sop == (idx_r == 8'h00))
    else $error("start flag off the first beat");
  a_ctl_len: assert property (vld && ctl_r |-> eop == (idx_r == 8'h09))
    else $error("control packet not ten beats");
  a_ctl_clean: assert property (vld && ctl_r |-> data[DW-1:4] == '0)
    else $error("control beat upper bits set");
  a_hdr_clean: assert property (vld && !ctl_r && idx_r == 8'h00 |-> data[DW-1:4] == '0)
    else $error("video header upper bits set");
  a_ctl_gapless: assert property (take && ctl_r && !eop ##1 rdy |-> vld)
    else $error("gap inside control packet");
  c_video_end: cover property (take && eop && !ctl_r);
endmodule
`default_nettype wire

/* File: tb/video_frame_memory_reader_tb.sv */
// Purpose: self-checking bench, frame reader facing frame sink
// Assumes: default build, 24-bit patterns in 64-bit words
// Notes: bench plays apb master and memory; queues hold expectations
`timescale 1ns/10ps
`default_nettype none
module video_frame_memory_reader_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, mem_addr, raddr = 32'h0;
  logic pready, pslverr, rerr, irq, mem_rd, pix_vld, pix_eop, frame_done, pend = 1'b0;
  logic mem_wait = 1'b1, mem_rvalid = 1'b0, stall = 1'b0;
  logic [63:0] mem_rdata = 64'h0, mem [0:63];
  logic [23:0] pix, exp_q[$];
  logic [31:0] addr_q[$];
  logic [15:0] wid, hgt, exp_w, exp_h;
  logic [3:0] ilace, exp_il;
  int seed = 22, fail_count = 0, checks = 0, cyc = 0, done_cnt = 0, dly = 0;
  vid_stream_if #(.DW(24)) u_vid_stream_if ();
  frame_reader u_frame_reader (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .MEM_RD_O(mem_rd), .MEM_ADDR_O(mem_addr),
    .MEM_WAIT_I(mem_wait), .MEM_RDATA_I(mem_rdata), .MEM_RVALID_I(mem_rvalid), .VID_SRC(u_vid_stream_if));
  frame_sink #(.DW(24)) u_frame_sink (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .STALL_I(stall),
    .PIX_O(pix), .PIX_VLD_O(pix_vld), .PIX_EOP_O(pix_eop), .FRAME_DONE_O(frame_done),
    .WIDTH_O(wid), .HEIGHT_O(hgt), .ILACE_O(ilace), .VID_SNK(u_vid_stream_if));
  frame_stream_assertions #(.DW(24)) u_chk (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n),
    .vld(u_vid_stream_if.vld), .rdy(u_vid_stream_if.rdy), .data(u_vid_stream_if.data),
    .sop(u_vid_stream_if.sop), .eop(u_vid_stream_if.eop));
  always #25 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one transfer; request stands until the rising edge that sees pready high, no cycle count assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask
  // program one location, run exactly one frame, then check irq handling
  task run_frame(input logic s, input logic [31:0] a, input int w, input int p,
                 input logic [15:0] wd, input logic [15:0] ht, input logic m);
    logic [7:0] b;
    int n;
    b = s ? frame_reader_pkg::OFS_ADDR1 : frame_reader_pkg::OFS_ADDR0;
    exp_il = 4'($random(seed));
    apb(1'b1, b, a);
    apb(1'b1, b + 8'h04, 32'(w));
    apb(1'b1, b + 8'h08, 32'(p));
    rdc(b + 8'h08, 32'(p));
    apb(1'b1, frame_reader_pkg::OFS_SELECT, {31'h0, s});
    apb(1'b1, frame_reader_pkg::OFS_WIDTH, {16'h0, wd});
    apb(1'b1, frame_reader_pkg::OFS_HEIGHT, {16'h0, ht});
    apb(1'b1, frame_reader_pkg::OFS_ILACE, {28'h0, exp_il});
    apb(1'b1, frame_reader_pkg::OFS_IRQ_MASK, {31'h0, m});
    exp_w = wd > 16'h0780 ? 16'h0780 : wd;
    exp_h = ht > 16'h0438 ? 16'h0438 : ht;
    rdc(frame_reader_pkg::OFS_WIDTH, {16'h0, exp_w});
    for (int k = 0; k < w; k++)
      addr_q.push_back(a + 32'(8 * k));
    for (int i = 0; i < p; i++)
      exp_q.push_back(i / 2 < w ? 24'(mem[a / 8 + i / 2] >> (24 * (i % 2))) : 24'h0);
    n = done_cnt;
    apb(1'b1, frame_reader_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, frame_reader_pkg::OFS_CTRL, 32'h0);
    for (int t = 0; t < 4000 && done_cnt == n; t++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    check(done_cnt, n + 1);
    check(addr_q.size(), 0);
    check(irq, m);
    rdc(frame_reader_pkg::OFS_STATUS, 32'h0);
    rdc(frame_reader_pkg::OFS_IRQ_STAT, 32'h1);
    apb(1'b1, frame_reader_pkg::OFS_IRQ_STAT, 32'h1);
    rdc(frame_reader_pkg::OFS_IRQ_STAT, 32'h0);
    check(irq, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // memory and sink side
  // ----------------------------------------------------------------
  // one read outstanding; data lines carry noise whenever not valid
  always @(posedge clk_sys)
  begin
    mem_wait <= 1'($random(seed));
    mem_rvalid <= pend && dly == 0;
    mem_rdata <= pend && dly == 0 ? mem[raddr[8:3]] : {$random(seed), $random(seed)};
    stall <= ($random(seed) & 3) == 0;
    if (mem_rd && !mem_wait)
    begin
      check(mem_addr, addr_q.size() > 0 ? addr_q.pop_front() : 32'hffff_ffff);
      raddr <= mem_addr;
      pend <= 1'b1;
      dly <= $random(seed) & 3;
    end
    else if (pend)
    begin
      pend <= dly != 0;
      dly <= dly - 1;
    end
    if (pix_vld)
    begin
      check(pix, exp_q.size() > 0 ? exp_q.pop_front() : 24'hx);
      check(pix_eop, exp_q.size() == 0);
    end
    if (frame_done)
    begin
      done_cnt++;
      check(exp_q.size(), 0);
      check(wid, exp_w);
      check(hgt, exp_h);
      check(ilace, exp_il);
    end
  end
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = {$random(seed), $random(seed)};
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(frame_reader_pkg::OFS_SELECT, 32'h0);
    rdc(frame_reader_pkg::OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    check({rerr, rdat}, 33'h100000000);
    run_frame(1'b0, 32'h40, 3, 6, 16'd640, 16'd480, 1'b1);
    run_frame(1'b1, 32'h100, 2, 5, 16'hffff, 16'h0500, 1'b0);
    run_frame(1'b0, 32'h40, 0, 0, 16'd8, 16'd4, 1'b1);
    run_frame(1'b1, 32'h100, 1, 1, 16'd1, 16'd1, 1'b0);
    check(done_cnt, 4);
    conclude();
  end
endmodule
`default_nettype wire
